// *** inc/scss_consts.svh ***
/*
 * Constants for the system clock source select block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by its bare name.
 */
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCSS_ADDR_CTRL_ONE 4'h0
`define SCSS_ADDR_FREQ_SEL 4'h1
`define SCSS_ADDR_STATUS 4'h2
`define SCSS_ADDR_CONFIG 4'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define SCSS_NEW_DIVIDER_FIELD_LSB 0
`define SCSS_NEW_SOURCE_FIELD_LSB 4
`define SCSS_CFG_EXT_LSB 0
`define SCSS_CFG_RST_LSB 4
`define SCSS_CFG_CLOCK_OUTPUT_PIN_BIT 7

// ****************************************************************
// Reset values
// ****************************************************************
`define SCSS_FREQ_SEL_RESET 4'h0
`define SCSS_CONFIG_RESET 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SCSS_OST_CYCLES 1024
`define SCSS_READY_CYCLES 16

`endif

// *** inc/scss_pkg.sv ***
/*
 * Types for the system clock source select block.
 * Assumes the constants header sits beside it.
 */
package scss_pkg;

  // Source codes of the new-source and reset-source fields.
  typedef enum logic [2:0]
  {
    SCSS_SRC_FAST_PLL = 3'h1,
    SCSS_SRC_EXT_PLL = 3'h2,
    SCSS_SRC_SLOW = 3'h5,
    SCSS_SRC_FAST = 3'h6,
    SCSS_SRC_EXT = 3'h7,
    SCSS_SRC_FAST_ALT = 3'h0,
    SCSS_SRC_RSVD3 = 3'h3,
    SCSS_SRC_RSVD4 = 3'h4
  } scss_src_t;

  // External oscillator configuration codes.
  typedef enum logic [2:0]
  {
    SCSS_EXT_LOW_GAIN = 3'h0,
    SCSS_EXT_MED_GAIN = 3'h1,
    SCSS_EXT_HIGH_GAIN = 3'h2,
    SCSS_EXT_OFF = 3'h4,
    SCSS_EXT_CLK_LOW = 3'h5,
    SCSS_EXT_CLK_MED = 3'h6,
    SCSS_EXT_CLK_HIGH = 3'h7,
    SCSS_EXT_RSVD3 = 3'h3
  } scss_ext_t;

  typedef enum logic [1:0]
  {
    SCSS_ST_IDLE = 2'h0,
    SCSS_ST_WAIT = 2'h1,
    SCSS_ST_SWITCH = 2'h2
  } scss_state_t;

endpackage

// *** rtl/scss_top.sv ***
/*
 * System clock source select: holds the source and divider selection,
 * waits for a new source to run before switching, steers the amplifier
 * gain and power level, and makes the Fosc/4 clock output.
 * Assumes the oscillators are outside and report their clocks as enable
 * pulses synchronous to clock; the external party keeps
 * its crystal in the range that the chosen gain mode is meant for.
 */
//
// Behaviour
// - Fast oscillator frequency chosen by software register
// - Slow internal oscillator fixed at 31 kHz
// - Times-four multiplier usable on external clock
// - Source and divider fields request clock switch
// - Reset source taken from configuration fields
// - Clock output toggles at one quarter system rate
// - Clock output only where second pin unused
// - External clock mode frees the second pin
// - External clock has three power levels
// - External clock skips oscillator start-up timer
// - Stopped external clock halts, state kept
// - Resonator modes map to low, medium, high gain
`timescale 1ns/10ps
`include "scss_consts.svh"

module scss_top
#(
  parameter int OST_CYCLES = `SCSS_OST_CYCLES, // Start-up timer length.
  parameter int READY_CYCLES = `SCSS_READY_CYCLES // Settle time for running sources.
)
(
  input wire logic clock, // System clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [3:0] addr, // Register address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [7:0] config_word_one_high, // Configuration word.
  input wire logic ext_clk_en, // One pulse per external clock edge.
  input wire logic fast_en, // One pulse per fast oscillator edge.
  input wire logic slow_en, // One pulse per slow oscillator edge.
  input wire logic osc_second_pin_in, // Second pin input level.
  output logic [7:0] rdata, // Read data, one cycle after rd.
  output logic [3:0] internal_freq_select, // Fast oscillator frequency code.
  output scss_pkg::scss_src_t cur_source, // Active system clock source.
  output logic [3:0] cur_divider, // Active divider code.
  output logic pll_on, // Multiplier enabled.
  output logic [1:0] amp_gain, // Amplifier gain, 0 off to 3 high.
  output logic [1:0] ext_power, // External clock power, 0 off to 3 high.
  output logic sys_clk_en, // Gated system clock enable pulse.
  output logic osc_second_pin_out, // Clock output level.
  output logic osc_second_pin_oe_n, // Low while the pin is driven.
  output logic gpio_free // Second pin free for general I/O.
);
  import scss_pkg::*;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function automatic logic uses_ext(input scss_src_t s);
    uses_ext = (s == SCSS_SRC_EXT) || (s == SCSS_SRC_EXT_PLL);
  endfunction

  function automatic logic src_tick(input scss_src_t s, input logic e, input logic f, input logic l);
    src_tick = uses_ext(s) ? e : ((s == SCSS_SRC_SLOW) ? l : f);
  endfunction

  function automatic logic [11:0] div_limit(input logic [3:0] d);
    div_limit = 12'h001 << ((d > 4'h9) ? 4'h9 : d);
  endfunction

  scss_ext_t ext_cfg;
  logic is_ext_clock_mode;
  logic is_resonator;
  logic cfg_clock_output_pin;
  assign ext_cfg = scss_ext_t'(config_word_one_high[`SCSS_CFG_EXT_LSB +: 3]);
  assign cfg_clock_output_pin = config_word_one_high[`SCSS_CFG_CLOCK_OUTPUT_PIN_BIT];
  assign is_ext_clock_mode = (ext_cfg == SCSS_EXT_CLK_LOW) || (ext_cfg == SCSS_EXT_CLK_MED) ||
                             (ext_cfg == SCSS_EXT_CLK_HIGH);
  assign is_resonator = (ext_cfg == SCSS_EXT_LOW_GAIN) || (ext_cfg == SCSS_EXT_MED_GAIN) ||
                        (ext_cfg == SCSS_EXT_HIGH_GAIN);

  // ****************************************************************
  // Registers and switch sequencer
  // ****************************************************************
  scss_state_t state, next_state;
  scss_src_t req_source, next_req_source;
  scss_src_t next_cur_source;
  logic [3:0] req_divider, next_req_divider;
  logic [3:0] next_cur_divider;
  logic [3:0] next_internal_freq_select;
  logic [11:0] wait_cnt, next_wait_cnt;
  logic [11:0] wait_len;
  logic booted, next_booted;
  logic [7:0] next_rdata;
  logic new_tick;

  assign new_tick = src_tick(req_source, ext_clk_en, fast_en, slow_en);
  // External clock mode needs no start-up timer; resonators do.
  assign wait_len = (uses_ext(req_source) && !is_ext_clock_mode) ? 12'(OST_CYCLES) : 12'(READY_CYCLES);

  always_comb
  begin
    next_state = state;
    next_req_source = req_source;
    next_req_divider = req_divider;
    next_cur_source = cur_source;
    next_cur_divider = cur_divider;
    next_internal_freq_select = internal_freq_select;
    next_wait_cnt = wait_cnt;
    next_booted = 1'b1;
    next_rdata = 8'h00;
    if (!booted)
    begin
      // Reset source is caught once the reset has released.
      next_cur_source = scss_src_t'(config_word_one_high[`SCSS_CFG_RST_LSB +: 3]);
      next_req_source = next_cur_source;
      next_cur_divider = 4'h0;
      next_req_divider = 4'h0;
    end
    else
    begin
      if (wr && addr == `SCSS_ADDR_CTRL_ONE)
      begin
        next_req_source = scss_src_t'(wdata[`SCSS_NEW_SOURCE_FIELD_LSB +: 3]);
        next_req_divider = wdata[`SCSS_NEW_DIVIDER_FIELD_LSB +: 4];
        next_state = SCSS_ST_WAIT;
        next_wait_cnt = 12'h000;
      end
      else
      begin
        unique case (state)
          SCSS_ST_IDLE:
          begin
            next_state = SCSS_ST_IDLE;
          end
          SCSS_ST_WAIT:
          begin
            // Counting only source edges proves the new source runs.
            if (new_tick)
            begin
              next_wait_cnt = wait_cnt + 12'h001;
            end
            if (wait_cnt >= wait_len)
            begin
              next_state = SCSS_ST_SWITCH;
            end
          end
          SCSS_ST_SWITCH:
          begin
            // Swap on a new source edge so no short pulse reaches the core.
            if (new_tick)
            begin
              next_cur_source = req_source;
              next_cur_divider = req_divider;
              next_state = SCSS_ST_IDLE;
            end
          end
        endcase
      end
      if (wr && addr == `SCSS_ADDR_FREQ_SEL)
      begin
        next_internal_freq_select = (wdata[3:0] > 4'h8) ? 4'h8 : wdata[3:0];
      end
      if (rd)
      begin
        unique case (addr)
          `SCSS_ADDR_CTRL_ONE: next_rdata = {1'b0, req_source, req_divider};
          `SCSS_ADDR_FREQ_SEL: next_rdata = {4'h0, internal_freq_select};
          `SCSS_ADDR_STATUS: next_rdata = {(state != SCSS_ST_IDLE), cur_source, cur_divider};
          `SCSS_ADDR_CONFIG: next_rdata = config_word_one_high;
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= SCSS_ST_IDLE;
      req_source <= SCSS_SRC_FAST_ALT;
      req_divider <= 4'h0;
      cur_source <= SCSS_SRC_FAST_ALT;
      cur_divider <= 4'h0;
      internal_freq_select <= `SCSS_FREQ_SEL_RESET;
      wait_cnt <= 12'h000;
      booted <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      req_source <= next_req_source;
      req_divider <= next_req_divider;
      cur_source <= next_cur_source;
      cur_divider <= next_cur_divider;
      internal_freq_select <= next_internal_freq_select;
      wait_cnt <= next_wait_cnt;
      booted <= next_booted;
      rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Oscillator mode outputs, divider and clock output
  // ****************************************************************
  logic next_pll_on;
  logic [1:0] next_amp_gain, next_ext_power;
  logic [11:0] div_cnt, next_div_cnt;
  logic [1:0] q_cnt, next_q_cnt;
  logic next_sys_clk_en, next_pin_out, next_pin_oe_n, next_gpio_free;
  logic cur_tick;

  // A stopped external clock gives no ticks: everything downstream holds.
  assign cur_tick = src_tick(cur_source, ext_clk_en, fast_en, slow_en);

  always_comb
  begin
    next_pll_on = (cur_source == SCSS_SRC_EXT_PLL) || (cur_source == SCSS_SRC_FAST_PLL);
    next_amp_gain = 2'h0;
    next_ext_power = 2'h0;
    unique case (ext_cfg)
      SCSS_EXT_LOW_GAIN: next_amp_gain = 2'h1;
      SCSS_EXT_MED_GAIN: next_amp_gain = 2'h2;
      SCSS_EXT_HIGH_GAIN: next_amp_gain = 2'h3;
      SCSS_EXT_CLK_LOW: next_ext_power = 2'h1;
      SCSS_EXT_CLK_MED: next_ext_power = 2'h2;
      SCSS_EXT_CLK_HIGH: next_ext_power = 2'h3;
      default: next_ext_power = 2'h0;
    endcase
    next_div_cnt = div_cnt;
    next_q_cnt = q_cnt;
    next_sys_clk_en = 1'b0;
    if (cur_tick)
    begin
      if (div_cnt + 12'h001 >= div_limit(cur_divider))
      begin
        next_div_cnt = 12'h000;
        next_sys_clk_en = 1'b1;
        next_q_cnt = q_cnt + 2'h1;
      end
      else
      begin
        next_div_cnt = div_cnt + 12'h001;
      end
    end
    // Resonators own the second pin, so it is never driven then.
    next_gpio_free = !is_resonator;
    next_pin_oe_n = !(cfg_clock_output_pin && !is_resonator);
    next_pin_out = next_pin_oe_n ? 1'b0 : next_q_cnt[1];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pll_on <= 1'b0;
      amp_gain <= 2'h0;
      ext_power <= 2'h0;
      div_cnt <= 12'h000;
      q_cnt <= 2'h0;
      sys_clk_en <= 1'b0;
      osc_second_pin_out <= 1'b0;
      osc_second_pin_oe_n <= 1'b1;
      gpio_free <= 1'b0;
    end
    else
    begin
      pll_on <= next_pll_on;
      amp_gain <= next_amp_gain;
      ext_power <= next_ext_power;
      div_cnt <= next_div_cnt;
      q_cnt <= next_q_cnt;
      sys_clk_en <= next_sys_clk_en;
      osc_second_pin_out <= next_pin_out;
      osc_second_pin_oe_n <= next_pin_oe_n;
      gpio_free <= next_gpio_free;
    end
  end

endmodule

// *** dv/scss_osc_model.sv ***
/* Behavioural oscillators at the far side: external clock, fast and slow internal.
   Assumes clock is the fast sampling clock and edges arrive as one-cycle pulses. */
`timescale 1ns/10ps
module scss_osc_model
(
  input wire logic clock, // Sampling clock.
  input wire logic nrst, // Reset, active low.
  input wire logic ext_run, // External clock running.
  input wire logic [1:0] amp_gain, // Gain chosen by the block; picks the crystal fitted.
  output logic ext_clk_en, // External edge pulse.
  output logic fast_en, // Fast oscillator pulse.
  output logic slow_en // Slow oscillator pulse.
);
  int cnt;
  int per;
  // The board fits a crystal that suits the gain in use; a logic clock runs fast.
  always_comb
  begin
    unique case (amp_gain)
      2'h1: per = 12;
      2'h2: per = 6;
      default: per = 3;
    endcase
  end
  // The external clock just stops, with no last pulse, as a real oscillator would.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 0;
      ext_clk_en <= 1'b0;
      fast_en <= 1'b0;
      slow_en <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      ext_clk_en <= ext_run && (cnt % per == 0);
      fast_en <= (cnt % 2 == 0);
      slow_en <= (cnt % 5 == 0);
    end
  end
endmodule

// *** dv/scss_checker.sv ***
/* Port checker for the clock source select block.
   Assumes it is bound to scss_top and sees only its ports. */
`timescale 1ns/10ps
module scss_checker
import scss_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic [3:0] addr, // Address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [7:0] config_word_one_high, // Configuration.
  input wire logic ext_clk_en, // External pulse.
  input wire logic [7:0] rdata, // Read data.
  input wire logic [3:0] internal_freq_select, // Fast code.
  input wire scss_pkg::scss_src_t cur_source, // Source.
  input wire logic [3:0] cur_divider, // Divider.
  input wire logic pll_on, // Multiplier.
  input wire logic [1:0] amp_gain, // Gain.
  input wire logic [1:0] ext_power, // Power.
  input wire logic sys_clk_en, // System pulse.
  input wire logic osc_second_pin_out, // Clock out.
  input wire logic osc_second_pin_oe_n, // Enable, low drives.
  input wire logic gpio_free // Pin free.
);
  logic [2:0] ec;
  logic [1:0] gexp;
  logic [1:0] pexp;
  logic [3:0] clamp;
  logic [6:0] stat;
  logic pll_exp;
  assign ec = config_word_one_high[2:0];
  assign gexp = (ec < 3'h3) ? ec[1:0] + 2'h1 : 2'h0;
  assign pexp = (ec > 3'h4) ? ec[1:0] - 2'h0 : 2'h0;
  assign clamp = (wdata[3:0] > 4'h8) ? 4'h8 : wdata[3:0];
  assign stat = {cur_source, cur_divider};
  assign pll_exp = (cur_source == SCSS_SRC_FAST_PLL) || (cur_source == SCSS_SRC_EXT_PLL);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_status_read: assert property (rd && addr == 4'h2 |=> rdata[6:0] == $past(stat)) else $error("bad status");
  a_freq_clamp: assert property (wr && addr == 4'h1 |=> internal_freq_select == $past(clamp)) else $error("bad freq");
  a_switch_wait: assert property (wr && addr == 4'h0 |=> $stable(cur_source) [*2]) else $error("early switch");
  a_pll_map: assert property (1 |=> pll_on == $past(pll_exp)) else $error("bad pll");
  a_gain_map: assert property (1 |=> amp_gain == $past(gexp)) else $error("bad gain");
  a_power_map: assert property (1 |=> ext_power == $past(pexp)) else $error("bad power");
  a_pin_free: assert property (1 |=> gpio_free == $past(ec > 3'h2)) else $error("bad gpio free");
  a_out_enable: assert property (1 |=> osc_second_pin_oe_n == !$past(config_word_one_high[7] && ec > 3'h2))
    else $error("bad out enable");
  a_out_quiet: assert property (osc_second_pin_oe_n |-> !osc_second_pin_out) else $error("out not quiet");
  a_ext_halt: assert property ((cur_source == SCSS_SRC_EXT && !ext_clk_en) [*3] |-> !sys_clk_en)
    else $error("runs without clock");
  c_fast: cover property (cur_source == SCSS_SRC_FAST);
  c_clock_output_pin: cover property (!osc_second_pin_oe_n && $rose(osc_second_pin_out));
  c_halt: cover property ((cur_source == SCSS_SRC_EXT && !ext_clk_en) [*3]);
endmodule
bind scss_top scss_checker scss_checker_inst (.clock, .nrst, .addr, .wdata, .wr, .rd, .config_word_one_high,
  .ext_clk_en, .rdata, .internal_freq_select, .cur_source, .cur_divider, .pll_on, .amp_gain, .ext_power,
  .sys_clk_en, .osc_second_pin_out, .osc_second_pin_oe_n, .gpio_free);

// *** dv/tb_top.sv ***
/* Self-checking bench for the clock source select block.
   Assumes the oscillator model and checker compile beside it; counts are shortened. */
`timescale 1ns/10ps
module tb_top;
  import scss_pkg::*;
  logic clock = 0, nrst = 0, wr = 0, rd = 0, ext_run = 1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, cfg = 8'hF5, d, rdata;
  logic ext_clk_en, fast_en, slow_en, pll_on, sys_clk_en, pin_out, oe_n, gpio_free, prev;
  logic [3:0] freq, cur_divider;
  logic [1:0] amp_gain, ext_power;
  scss_src_t cur_source;
  int miscompares = 0, check_count = 0, n, p, e;
  logic [7:0] rows [5][2] = '{'{8'h00, 8'h00}, '{8'h03, 8'h03}, '{8'h08, 8'h08}, '{8'h09, 8'h08}, '{8'hFF, 8'h08}};
  always #5 clock = ~clock;
  scss_osc_model scss_osc_model_inst (.clock(clock), .nrst(nrst), .ext_run(ext_run), .amp_gain(amp_gain),
    .ext_clk_en(ext_clk_en), .fast_en(fast_en), .slow_en(slow_en));
  scss_top #(.OST_CYCLES(8), .READY_CYCLES(2)) scss_top_inst (.clock(clock), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .config_word_one_high(cfg), .ext_clk_en(ext_clk_en), .fast_en(fast_en),
    .slow_en(slow_en), .osc_second_pin_in(1'b0), .rdata(rdata), .internal_freq_select(freq),
    .cur_source(cur_source), .cur_divider(cur_divider), .pll_on(pll_on), .amp_gain(amp_gain),
    .ext_power(ext_power), .sys_clk_en(sys_clk_en), .osc_second_pin_out(pin_out),
    .osc_second_pin_oe_n(oe_n), .gpio_free(gpio_free));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Counts cycles until the source settles; a hang shows up as a mismatch on the source.
  task automatic wait_src(input logic [2:0] s);
    n = 0;
    while (cur_source !== s && n < 200)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk(cur_source, s);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000 miscompares++;
    end_sim();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge clock);
    #1 chk(oe_n, 1'b1);
    @(posedge clock) nrst <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(cur_source, 3'h7);
    chk(cur_divider, 4'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(4'h1, rows[i][0]);
      rd_reg(4'h1, d);
      chk(d, rows[i][1]);
      chk(freq, rows[i][1][3:0]);
    end
    rd_reg(4'h9, d);
    chk(d, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clock) cfg <= {5'h1E, c[2:0]};
      repeat (2) @(posedge clock);
      #1 chk(amp_gain, (c < 3) ? c + 1 : 0);
      chk(ext_power, (c > 4) ? c - 4 : 0);
      chk(gpio_free, c > 2);
      chk(oe_n, c < 3);
    end
    @(posedge clock) cfg <= 8'hF5;
    p = 0;
    e = 0;
    prev = pin_out;
    repeat (100)
    begin
      @(posedge clock);
      #1 p += sys_clk_en;
      e += (pin_out && !prev);
      prev = pin_out;
    end
    chk(e > 4 && p >= 4 * e - 4 && p <= 4 * e + 4, 1'b1);
    @(posedge clock) ext_run <= 1'b0;
    repeat (4) @(posedge clock);
    p = 0;
    repeat (40)
    begin
      @(posedge clock);
      #1 p += sys_clk_en;
    end
    chk(p, 0);
    chk(cur_source, 3'h7);
    @(posedge clock) ext_run <= 1'b1;
    wr_reg(4'h0, 8'h61);
    rd_reg(4'h2, d);
    chk(d[7], 1'b1);
    chk(cur_source, 3'h7);
    wait_src(3'h6);
    chk(cur_divider, 4'h1);
    // The multiplier flag follows the source one cycle later.
    @(posedge clock);
    #1 chk(pll_on, 1'b0);
    wr_reg(4'h0, 8'h20);
    wait_src(3'h2);
    @(posedge clock);
    #1 chk(pll_on, 1'b1);
    wr_reg(4'h0, 8'h70);
    wait_src(3'h7);
    chk(n < 18, 1'b1);
    // A fast crystal on high gain: the start-up timer must now run its full length.
    @(posedge clock) cfg <= 8'hF2;
    wr_reg(4'h0, 8'h60);
    wait_src(3'h6);
    wr_reg(4'h0, 8'h70);
    wait_src(3'h7);
    chk(n > 20, 1'b1);
    wr_reg(4'h0, 8'h50);
    wait_src(3'h5);
    p = 0;
    repeat (50)
    begin
      @(posedge clock);
      #1 p += sys_clk_en;
    end
    chk(p, 8'd10);
    // Mid-run reset with the clock output off: the reset source is taken afresh.
    @(posedge clock) nrst <= 1'b0;
    cfg <= 8'h65;
    @(posedge clock);
    #1 chk(cur_source, 3'h0);
    chk(oe_n, 1'b1);
    @(posedge clock) nrst <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(cur_source, 3'h6);
    chk(oe_n, 1'b1);
    end_sim();
  end
endmodule
